// ===== rtl/tcomp_pkg.sv
// constants, types and helper functions for the trim compensation control
// assumes a byte-wide register port and one second tick from the clock core
package tcomp_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CURVE = 8'h0c;
  localparam logic [7:0] ADDR_GAIN = 8'h0d;
  localparam logic [7:0] ADDR_FCAP = 8'h0e;
  localparam logic [7:0] ADDR_FPULSE = 8'h0f;

  // ==========================================================================
  // field layout and reset values
  localparam int BIT_SENSE_EN = 7;
  localparam int BIT_BATT_EN = 6;
  localparam int BIT_BATT_RATE = 5;
  localparam int GAIN_W = 4;
  localparam int CURVE_W = 7;
  localparam int CAP_W = 6;
  localparam int PULSE_W = 3;
  localparam int TEMP_W = 10;
  localparam logic [7:0] CTRL_WMASK = 8'hef; // bit 4 always zero
  localparam logic [6:0] CURVE_RESET = 7'h00;
  localparam logic [7:0] CTRL_RESET = 8'h08; // enables off, unity gain

  // ==========================================================================
  // arithmetic constants
  localparam int CURVE_SCALE = 1024; // curvature stored as |alpha| * 1024
  localparam int CURVE_SHIFT = 10;
  localparam logic [9:0] TEMP_REF_CODE = 10'h314; // 25 C in half degrees
  localparam int TEMP_SQ_SHIFT = 2; // half-degree squared to degree squared
  localparam int CORR_MAX = 255;
  localparam int CAP_CENTER = 32; // code 0 is +32 ppm
  localparam int CAP_MAX_PPM = 32;
  localparam int CAP_MIN_PPM = -31;
  localparam int PULSE_STEP = 32;
  localparam int PULSE_MAX_CODE = 5;
  localparam logic [2:0] PULSE_NEG_CODE = 3'h7;
  localparam int RECIP_SHIFT = 6; // gain reciprocal is 512 / code

  // ==========================================================================
  // timing, in seconds of the time base
  localparam int SEC_PER_MIN = 60;
  localparam int BATT_SLOW_MIN = 10;
  localparam int BATT_FAST_MIN = 1;
  localparam logic [9:0] BATT_SLOW_S = 10'(BATT_SLOW_MIN * SEC_PER_MIN);
  localparam logic [9:0] BATT_FAST_S = 10'(BATT_FAST_MIN * SEC_PER_MIN);

  typedef enum logic [1:0] {
    TC_IDLE = 2'b00,
    TC_SENSE = 2'b01,
    TC_CALC = 2'b11
  } tcomp_state_t;

  // ppm represented by a final pulse trim code
  function automatic logic signed [9:0] tcomp_pulse_ppm(input logic [2:0] c);
    case (c)
      3'h0: tcomp_pulse_ppm = 10'sh000;
      3'h1: tcomp_pulse_ppm = 10'sh020;
      3'h2: tcomp_pulse_ppm = 10'sh040;
      3'h3: tcomp_pulse_ppm = 10'sh060;
      3'h4: tcomp_pulse_ppm = 10'sh080;
      3'h5: tcomp_pulse_ppm = 10'sh0a0;
      3'h6: tcomp_pulse_ppm = 10'sh0c4;
      default: tcomp_pulse_ppm = -10'sh020;
    endcase
  endfunction

  // initial two-bit pulse trim as a final three-bit code
  function automatic logic [2:0] tcomp_init_pulse(input logic [1:0] c);
    case (c)
      2'h1: tcomp_init_pulse = 3'h1;
      2'h3: tcomp_init_pulse = PULSE_NEG_CODE;
      default: tcomp_init_pulse = 3'h0;
    endcase
  endfunction

  // 512 / gain code; codes outside the legal span are clamped
  function automatic logic [7:0] tcomp_gain_recip(input logic [3:0] g);
    case (g)
      4'h5: tcomp_gain_recip = 8'h66;
      4'h6: tcomp_gain_recip = 8'h55;
      4'h7: tcomp_gain_recip = 8'h49;
      4'h8: tcomp_gain_recip = 8'h40;
      4'h9: tcomp_gain_recip = 8'h39;
      4'ha: tcomp_gain_recip = 8'h33;
      4'hb: tcomp_gain_recip = 8'h2f;
      4'hc, 4'hd, 4'he, 4'hf: tcomp_gain_recip = 8'h2b;
      default: tcomp_gain_recip = 8'h80;
    endcase
  endfunction

endpackage

// ===== rtl/tcomp_calc_if.sv
// carrier between the control and the trim arithmetic
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface tcomp_calc_if;
  logic start;
  logic [9:0] temp;
  logic [6:0] curve;
  logic [3:0] gain;
  logic [5:0] icap;
  logic [1:0] ipulse;
  logic done;
  logic [5:0] res_cap;
  logic [2:0] res_pulse;

  modport ctrl (
    output start, temp, curve, gain, icap, ipulse,
    input done, res_cap, res_pulse
  );
  modport calc (
    input start, temp, curve, gain, icap, ipulse,
    output done, res_cap, res_pulse
  );
endinterface

// ===== rtl/tcomp_calc.sv
// trim arithmetic: temperature code and settings in, final trims out
// assumes inputs are stable in the cycle that start is high
`timescale 1ns/1ps
module tcomp_calc
  import tcomp_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset, high
  tcomp_calc_if.calc cif // request and result
);

  logic signed [11:0] dt;
  logic [10:0] dmag;
  logic [21:0] dsq;
  logic [28:0] prod;
  logic [16:0] corr_raw;
  logic signed [11:0] corr;
  logic signed [11:0] cap_ppm;
  logic signed [11:0] total;
  logic signed [11:0] quot;
  logic signed [11:0] rem;
  logic signed [20:0] scaled;
  logic signed [11:0] steps;
  logic [2:0] next_pulse;
  logic [5:0] next_cap;
  logic [5:0] res_cap;
  logic [2:0] res_pulse;
  logic done;

  // ==========================================================================
  // correction: positive ppm = |alpha| * dT^2, the crystal runs slow
  always_comb begin
    dt = $signed({2'b00, cif.temp}) - $signed({2'b00, TEMP_REF_CODE});
    dmag = dt[11] ? 11'(-dt) : dt[10:0];
    dsq = 22'(dmag * dmag);
    prod = 29'(cif.curve * dsq);
    corr_raw = prod[28:CURVE_SHIFT + TEMP_SQ_SHIFT];
    corr = (corr_raw > 17'(CORR_MAX)) ? 12'sd255
                                      : $signed({3'b000, corr_raw[8:0]});
    cap_ppm = 12'(CAP_CENTER) - $signed({6'h00, cif.icap});
    total = cap_ppm + 12'(tcomp_pulse_ppm(tcomp_init_pulse(cif.ipulse)))
            + corr;
    // quotient defaults so the negative branch leaves no latch behind
    quot = 12'sd0;
    // digital part takes whole 32 ppm steps, analog keeps the remainder
    if (total < 12'(CAP_MIN_PPM)) begin
      next_pulse = PULSE_NEG_CODE;
      rem = total + 12'(PULSE_STEP);
    end else begin
      quot = (total + 12'sd31) >>> 5;
      if (quot > 12'(PULSE_MAX_CODE)) begin
        quot = 12'(PULSE_MAX_CODE);
      end
      next_pulse = quot[2:0];
      rem = total - 12'(quot * PULSE_STEP);
    end
    // gain rescales the analog step back to one ppm
    scaled = 21'(rem * $signed({1'b0, tcomp_gain_recip(cif.gain)}));
    steps = 12'(scaled >>> RECIP_SHIFT);
    if (steps > 12'(CAP_MAX_PPM)) begin
      steps = 12'(CAP_MAX_PPM);
    end else if (steps < 12'(CAP_MIN_PPM)) begin
      steps = 12'(CAP_MIN_PPM);
    end
    next_cap = 6'(12'(CAP_CENTER) - steps);
  end

  // results land together one cycle after start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      res_cap <= 6'h20;
      res_pulse <= 3'h0;
      done <= 1'b0;
    end else begin
      done <= cif.start;
      if (cif.start) begin
        res_cap <= next_cap;
        res_pulse <= next_pulse;
      end
    end
  end

  assign cif.done = done;
  assign cif.res_cap = res_cap;
  assign cif.res_pulse = res_pulse;

  a_pulse_code_legal: assert property (@(posedge ref_clk) disable iff (rst)
    cif.done |-> cif.res_pulse != 3'h6)
    else $error("pulse trim code 110 produced");

endmodule

// ===== rtl/tcomp_trim_ctrl.sv
// control and status for oscillator temperature compensation
// assumes a byte register port from the serial engine, a one-second tick,
// and a temperature converter answering sense_req with sense_done
//
// Operation
// - curvature register holds |alpha| times 1024 in seven bits, top bit zero
// - bit 7 of gain register enables sensing; cleared after reset
// - with sensing off, final trims equal the initial trims
// - bit 6 enables sensing on battery; defaults off
// - battery sensing is suppressed while battery is below 2.6 V
// - bit 5 picks battery period: 10 minutes or 1 minute
// - gain bits 3:0 scale analog step 0.5 to 1.5; bit 4 zero
// - final analog trim at 0x0e, read-only, bits 7:6 zero
// - final digital trim at 0x0f bits 2:0, read-only
// - digital codes map to 0,32..160,196,-32 ppm
// - curvature field is seven bits, used as a negative coefficient magnitude
// - digital trim skips or inserts pulses; analog trim sets load capacitance
// - initial analog trim spans +32 to -31 ppm, one ppm per code
`timescale 1ns/1ps
module tcomp_trim_ctrl
  import tcomp_pkg::*;
#(
  parameter int MAIN_PERIOD_S = 60 // main-supply period in seconds
) (
  input wire logic ref_clk, // 250 MHz core clock
  input wire logic rst, // async reset, high
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, next cycle
  input wire logic [5:0] initial_cap_trim, // initial analog trim code
  input wire logic [1:0] initial_pulse_trim, // initial digital trim code
  input wire logic on_battery, // running from backup battery
  input wire logic battery_low, // battery below 2.6 V
  input wire logic sec_tick, // one-cycle pulse each second
  output logic sense_req, // convert temperature, level
  input wire logic sense_done, // conversion ready, one cycle
  input wire logic [9:0] temp_code, // converted temperature
  output logic [5:0] cap_trim, // to load capacitor bank
  output logic [2:0] pulse_trim // to pulse skip/insert logic
);

  tcomp_calc_if cif ();

  logic [6:0] curve;
  logic [7:0] ctrl;
  logic [6:0] work_curve;
  logic [3:0] work_gain;
  logic [5:0] work_icap;
  logic [1:0] work_ipulse;
  logic [5:0] fcap;
  logic [2:0] fpulse;
  logic [9:0] sec_cnt;
  logic pend;
  tcomp_state_t state;
  logic [7:0] next_rdata;
  logic [6:0] next_curve;
  logic [7:0] next_ctrl;
  logic [6:0] next_work_curve;
  logic [3:0] next_work_gain;
  logic [5:0] next_work_icap;
  logic [1:0] next_work_ipulse;
  logic [5:0] next_fcap;
  logic [2:0] next_fpulse;
  logic [9:0] next_sec_cnt;
  logic next_pend;
  tcomp_state_t next_state;
  logic wr_curve;
  logic wr_ctrl;
  logic adopt;
  logic sense_en;
  logic batt_run;
  logic main_run;
  logic run;
  logic [9:0] period_s;
  logic tick_hit;
  logic start;

  // ==========================================================================
  // decode
  assign wr_curve = reg_wr && (reg_addr == ADDR_CURVE);
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_GAIN);
  // a write with the enable set is the moment new settings take effect
  assign adopt = wr_ctrl && reg_wdata[BIT_SENSE_EN];
  assign sense_en = ctrl[BIT_SENSE_EN];
  // battery sensing needs its own enable and a healthy battery
  assign batt_run = sense_en && on_battery && ctrl[BIT_BATT_EN]
                    && !battery_low;
  assign main_run = sense_en && !on_battery;
  assign run = batt_run || main_run;

  // period select; a count already past a shorter period fires on the next tick
  always_comb begin
    if (!on_battery) begin
      period_s = 10'(MAIN_PERIOD_S);
    end else if (ctrl[BIT_BATT_RATE]) begin
      period_s = BATT_FAST_S;
    end else begin
      period_s = BATT_SLOW_S;
    end
  end
  assign tick_hit = run && sec_tick && (sec_cnt >= period_s - 10'h001);
  assign start = (state == TC_IDLE) && run && (pend || tick_hit);

  // ==========================================================================
  // register file and working copies
  always_comb begin
    next_curve = curve;
    next_ctrl = ctrl;
    next_work_curve = work_curve;
    next_work_gain = work_gain;
    next_work_icap = work_icap;
    next_work_ipulse = work_ipulse;
    if (wr_curve) begin
      next_curve = reg_wdata[CURVE_W-1:0];
    end
    if (wr_ctrl) begin
      next_ctrl = reg_wdata & CTRL_WMASK;
    end
    // the arithmetic only ever sees settings latched here
    if (adopt) begin
      next_work_curve = wr_curve ? reg_wdata[CURVE_W-1:0] : curve;
      next_work_gain = reg_wdata[GAIN_W-1:0];
      next_work_icap = initial_cap_trim;
      next_work_ipulse = initial_pulse_trim;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      curve <= CURVE_RESET;
      ctrl <= CTRL_RESET;
      work_curve <= CURVE_RESET;
      work_gain <= CTRL_RESET[GAIN_W-1:0];
      work_icap <= 6'h00;
      work_ipulse <= 2'h0;
    end else begin
      curve <= next_curve;
      ctrl <= next_ctrl;
      work_curve <= next_work_curve;
      work_gain <= next_work_gain;
      work_icap <= next_work_icap;
      work_ipulse <= next_work_ipulse;
    end
  end

  // ==========================================================================
  // read path; the final trim registers have no write path at all
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CURVE: next_rdata = {1'b0, curve};
        ADDR_GAIN: next_rdata = ctrl;
        ADDR_FCAP: next_rdata = {2'b00, fcap};
        ADDR_FPULSE: next_rdata = {5'h00, fpulse};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // cycle scheduler: second counter, pending kick, sensing sequence
  always_comb begin
    next_sec_cnt = sec_cnt;
    next_pend = pend;
    next_state = state;
    if (!run) begin
      next_sec_cnt = 10'h000;
    end else if (tick_hit) begin
      next_sec_cnt = 10'h000;
    end else if (sec_tick) begin
      next_sec_cnt = sec_cnt + 10'h001;
    end
    // adoption sets pend; the cycle starts once idle and run is set, so new settings show without waiting
    if (adopt) begin
      next_pend = 1'b1;
    end else if (start || !sense_en) begin
      next_pend = 1'b0;
    end
    unique case (state)
      TC_IDLE: begin
        if (start) begin
          next_state = TC_SENSE;
        end
      end
      TC_SENSE: begin
        if (!sense_en) begin
          next_state = TC_IDLE;
        end else if (sense_done) begin
          next_state = TC_CALC;
        end
      end
      TC_CALC: begin
        if (!sense_en || cif.done) begin
          next_state = TC_IDLE;
        end
      end
      default: begin
        next_state = TC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sec_cnt <= 10'h000;
      pend <= 1'b0;
      state <= TC_IDLE;
    end else begin
      sec_cnt <= next_sec_cnt;
      pend <= next_pend;
      state <= next_state;
    end
  end

  assign sense_req = (state == TC_SENSE);
  assign cif.start = (state == TC_SENSE) && sense_en && sense_done;
  assign cif.temp = temp_code;
  assign cif.curve = work_curve;
  assign cif.gain = work_gain;
  assign cif.icap = work_icap;
  assign cif.ipulse = work_ipulse;

  tcomp_calc u_calc (
    .ref_clk(ref_clk),
    .rst(rst),
    .cif(cif.calc)
  );

  // ==========================================================================
  // final trims: follow the initial trims while off, else the last result
  always_comb begin
    next_fcap = fcap;
    next_fpulse = fpulse;
    if (!sense_en) begin
      next_fcap = initial_cap_trim;
      next_fpulse = tcomp_init_pulse(initial_pulse_trim);
    end else if ((state == TC_CALC) && cif.done) begin
      next_fcap = cif.res_cap;
      next_fpulse = cif.res_pulse;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fcap <= 6'h00;
      fpulse <= 3'h0;
    end else begin
      fcap <= next_fcap;
      fpulse <= next_fpulse;
    end
  end

  // capacitance code and pulse code go to separate trim mechanisms
  assign cap_trim = fcap;
  assign pulse_trim = fpulse;

  // ==========================================================================
  // checks
  sequence s_sense_taken;
    (state == TC_SENSE) && sense_en && sense_done;
  endsequence
  sequence s_calc_done;
    sense_en [*2] ##0 (state == TC_IDLE);
  endsequence

  // all checks share the core clock and reset
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_curve_top_zero: assert property (
    reg_rd && (reg_addr == ADDR_CURVE) |=> !reg_rdata[7]
      && (reg_rdata[6:0] == $past(curve)))
    else $error("curvature read wrong");
  a_enable_by_write: assert property (
    $rose(sense_en) |-> $past(wr_ctrl && reg_wdata[BIT_SENSE_EN]))
    else $error("sense enable rose without a write");
  a_disabled_initial: assert property (
    !sense_en |=> (cap_trim == $past(initial_cap_trim))
      && (pulse_trim == tcomp_init_pulse($past(initial_pulse_trim))))
    else $error("trims differ from initial while disabled");
  a_batt_off_idle: assert property (
    (state == TC_IDLE) && on_battery && !ctrl[BIT_BATT_EN] |=> state == TC_IDLE)
    else $error("battery cycle started while disabled");
  a_batt_low_idle: assert property (
    (state == TC_IDLE) && on_battery && battery_low |=> state == TC_IDLE)
    else $error("battery cycle started on low battery");
  a_gain_bit4_zero: assert property (
    reg_rd && (reg_addr == ADDR_GAIN) |=> !reg_rdata[4])
    else $error("gain bit 4 reads set");
  a_fcap_read: assert property (
    reg_rd && (reg_addr == ADDR_FCAP) |=> (reg_rdata[7:6] == 2'b00)
      && (reg_rdata[5:0] == $past(fcap)))
    else $error("final analog trim read wrong");
  a_fpulse_read: assert property (
    reg_rd && (reg_addr == ADDR_FPULSE) |=> (reg_rdata[7:3] == 5'h00)
      && (reg_rdata[2:0] == $past(fpulse)))
    else $error("final digital trim read wrong");
  a_atomic_update: assert property (
    s_sense_taken ##1 sense_en |=> (cap_trim == $past(cif.res_cap))
      && (pulse_trim == $past(cif.res_pulse)))
    else $error("final trims not updated together");
  a_cycle_ends: assert property (
    s_sense_taken |-> ##1 s_calc_done or ##[1:2] !sense_en)
    else $error("cycle did not finish in two cycles");

endmodule

// ===== test/tcomp_trim_ctrl_test.sv
// self-checking bench for the trim compensation control
// assumes the rtl/ package, interface and modules are compiled first
`timescale 1ns/1ps
module tcomp_trim_ctrl_test
  import tcomp_pkg::*;
;
  // ==========================================================================
  // signals and design
  localparam int LIMIT = 20000; // whole run needs about 3400 cycles
  logic ref_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [5:0] initial_cap_trim;
  logic [1:0] initial_pulse_trim;
  logic on_battery;
  logic battery_low;
  logic sec_tick;
  logic sense_req;
  logic sense_done;
  logic [9:0] temp_code;
  logic [5:0] cap_trim;
  logic [2:0] pulse_trim;
  int bad_count;
  int checked;
  int cycles;
  int n;

  // short main period keeps the periodic scenario cheap
  tcomp_trim_ctrl #(.MAIN_PERIOD_S(2)) dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .initial_cap_trim(initial_cap_trim),
    .initial_pulse_trim(initial_pulse_trim),
    .on_battery(on_battery),
    .battery_low(battery_low),
    .sec_tick(sec_tick),
    .sense_req(sense_req),
    .sense_done(sense_done),
    .temp_code(temp_code),
    .cap_trim(cap_trim),
    .pulse_trim(pulse_trim)
  );

  // ==========================================================================
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  // ==========================================================================
  // tasks
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data lands one cycle after the strobe is taken
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // final trims on the pins and in the read-back registers
  task automatic finals(input logic [5:0] c, input logic [2:0] p);
    check({2'h0, cap_trim}, {2'h0, c});
    check({5'h0, pulse_trim}, {5'h0, p});
    rd_chk(ADDR_FCAP, {2'h0, c});
    rd_chk(ADDR_FPULSE, {5'h0, p});
  endtask

  // pulse sec_tick until a cycle starts; k is max + 1 if none did
  task automatic count_ticks(input int max, output int k);
    k = max + 1;
    for (int i = 1; i <= max; i++) begin
      @(posedge ref_clk);
      sec_tick <= 1'b1;
      @(posedge ref_clk);
      sec_tick <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      if (sense_req === 1'b1) begin
        k = i;
        break;
      end
    end
  endtask

  task automatic wait_req();
    for (int i = 0; i < 20 && sense_req !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check({7'h0, sense_req}, 8'h01);
  endtask

  // curvature is zero, so the temperature value drops out of the result
  task automatic serve(input logic [5:0] c0, input logic [2:0] p0,
                       input logic [5:0] c1, input logic [2:0] p1);
    wait_req();
    @(posedge ref_clk);
    sense_done <= 1'b1;
    temp_code <= 10'h2a0;
    @(posedge ref_clk);
    sense_done <= 1'b0;
    #1;
    check({2'h0, cap_trim}, {2'h0, c0});
    check({5'h0, pulse_trim}, {5'h0, p0});
    repeat (2) @(posedge ref_clk);
    #1;
    finals(c1, p1);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    initial_cap_trim = 6'h15;
    initial_pulse_trim = 2'h3;
    on_battery = 1'b0;
    battery_low = 1'b0;
    sec_tick = 1'b0;
    sense_done = 1'b0;
    temp_code = 10'h2a0;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, sensing off so finals copy the initial trims
    rd_chk(ADDR_CURVE, 8'h00);
    rd_chk(ADDR_GAIN, 8'h08);
    finals(6'h15, 3'h7);
    // read-only finals ignore writes
    wr(ADDR_FCAP, 8'hff);
    wr(ADDR_FPULSE, 8'hff);
    finals(6'h15, 3'h7);
    // curvature is seven bits, top bit reads zero
    wr(ADDR_CURVE, 8'hff);
    rd_chk(ADDR_CURVE, 8'h7f);
    wr(ADDR_CURVE, 8'h23);
    rd_chk(ADDR_CURVE, 8'h23);
    wr(ADDR_CURVE, 8'h00);
    // every legal gain code, bit 4 written high must read zero
    for (int g = 4; g <= 12; g++) begin
      wr(ADDR_GAIN, 8'h30 | 8'(g));
      rd_chk(ADDR_GAIN, 8'h20 | 8'(g));
    end
    wr(ADDR_GAIN, 8'h08);
    // +1 ppm start; expected split is +32 digital and -31 analog
    initial_cap_trim <= 6'h1f;
    initial_pulse_trim <= 2'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    finals(6'h1f, 3'h0);
    wr(ADDR_GAIN, 8'h88);
    serve(6'h1f, 3'h0, 6'h3f, 3'h1);
    // clearing the enable returns to the initial trims
    wr(ADDR_GAIN, 8'h08);
    repeat (2) @(posedge ref_clk);
    #1;
    finals(6'h1f, 3'h0);
    // abort a conversion in flight, a late done is ignored
    wr(ADDR_GAIN, 8'h88);
    wait_req();
    wr(ADDR_GAIN, 8'h08);
    @(posedge ref_clk);
    sense_done <= 1'b1;
    @(posedge ref_clk);
    sense_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check({7'h0, sense_req}, 8'h00);
    finals(6'h1f, 3'h0);
    // main supply runs a cycle every main period
    wr(ADDR_GAIN, 8'h88);
    serve(6'h1f, 3'h0, 6'h3f, 3'h1);
    count_ticks(4, n);
    check({7'h0, n <= 2}, 8'h01);
    serve(6'h3f, 3'h1, 6'h3f, 3'h1);
    // battery mode without its enable: no cycles
    on_battery <= 1'b1;
    wr(ADDR_GAIN, 8'ha8);
    count_ticks(70, n);
    check({7'h0, n > 70}, 8'h01);
    // battery enabled but low: still no cycles
    battery_low <= 1'b1;
    wr(ADDR_GAIN, 8'he8);
    count_ticks(70, n);
    check({7'h0, n > 70}, 8'h01);
    battery_low <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    if (sense_req === 1'b1) begin
      serve(6'h3f, 3'h1, 6'h3f, 3'h1);
    end
    // fast battery rate: one cycle a minute
    count_ticks(70, n);
    check({7'h0, n >= 59 && n <= 60}, 8'h01);
    serve(6'h3f, 3'h1, 6'h3f, 3'h1);
    // slow battery rate: one cycle every ten minutes
    wr(ADDR_GAIN, 8'hc8);
    serve(6'h3f, 3'h1, 6'h3f, 3'h1);
    count_ticks(610, n);
    check({7'h0, n >= 599 && n <= 600}, 8'h01);
    serve(6'h3f, 3'h1, 6'h3f, 3'h1);
    end_of_test();
  end
endmodule
